// File: design/liu_mode_alarm.sv
// Functional notes
// - Channel 0 rate pin high gives E3, low defers to sonet select.
// - Channels 1 and 2: E3 pin high gives E3, low consults sonet select.
// - Sonet select high gives STS-1, low DS3; ignored when E3 selected.
// - Host mode ignores rate and all-ones pins; board grounds them.
// - Config source high enables host interface; low hands control to pins.
// - Host mode takes configuration from serially written registers instead.
// - Driver monitor alarm after 128 silent transmit periods, clears on pulse.
// - All-ones select sends alternating AMI marks every transmit period.
// - Loss-of-signal alarm high during loss; criterion differs E3 versus DS3/STS-1.
// - Loss-of-lock alarm when recovered clock deviates over 0.5 percent.
// - One high pulse per line code violation, low otherwise.
// - Test input low clears outputs_drive_en one clock later; other outputs keep driving; high for normal use.
// - Threshold select picks one of two levels, DS3/STS-1 only.
`timescale 1ns/100ps
module liu_mode_alarm (
    input wire logic clk,
    input wire logic rstn,
    input wire logic config_source_sel,
    input wire logic in_circuit_test_n,
    input wire logic ch0_e3_rate_sel,
    input wire logic ch1_e3_rate_sel,
    input wire logic ch2_e3_rate_sel,
    input wire logic [2:0] sonet_vs_t3_rate_sel,
    input wire logic [2:0] all_ones_tx_sel,
    input wire logic [2:0] signal_loss_threshold_sel,
    input wire logic [2:0] host_e3_rate_sel,
    input wire logic [2:0] host_sonet_rate_sel,
    input wire logic [2:0] host_all_ones_sel,
    input wire logic [2:0] transmit_clock,
    input wire logic [2:0] tx_data_pos,
    input wire logic [2:0] tx_data_neg,
    input wire logic [2:0] monitor_tip_in,
    input wire logic [2:0] monitor_ring_in,
    input wire logic [2:0] recovered_rx_clock,
    input wire logic [2:0] reference_clock_in,
    input wire logic [2:0] rx_line_pos,
    input wire logic [2:0] rx_line_neg,
    output logic [2:0] line_out_positive,
    output logic [2:0] line_out_negative,
    output logic [2:0] driver_monitor_alarm,
    output logic [2:0] rx_signal_loss_alarm,
    output logic [2:0] rx_lock_loss_alarm,
    output logic [2:0] code_violation_pulse,
    output logic [2:0] recovered_data_out,
    output logic [2:0] e3_mode_active,
    output logic [2:0] sts1_mode_active,
    output logic outputs_drive_en
);

    function automatic logic [2:0] rise(input logic [2:0] prev, input logic [2:0] cur);
        rise = cur & ~prev;
    endfunction

    // Clock pins are sampled as levels; each rising edge becomes a one-cycle tick
    logic [2:0] tx_clk_q, tx_clk_d;
    logic [2:0] rx_clk_q, rx_clk_d;
    logic [2:0] ref_clk_q, ref_clk_d;
    logic [2:0] tx_tick, rx_tick, ref_tick;

    always_comb begin
        tx_clk_d = transmit_clock;
        rx_clk_d = recovered_rx_clock;
        ref_clk_d = reference_clock_in;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_clk_q <= 3'h0;
            rx_clk_q <= 3'h0;
            ref_clk_q <= 3'h0;
        end else begin
            tx_clk_q <= tx_clk_d;
            rx_clk_q <= rx_clk_d;
            ref_clk_q <= ref_clk_d;
        end
    end

    assign tx_tick = rise(tx_clk_q, transmit_clock);
    assign rx_tick = rise(rx_clk_q, recovered_rx_clock);
    assign ref_tick = rise(ref_clk_q, reference_clock_in);

    // Mode selection
    liu_pkg::liu_rate_t rate_q [3], rate_d [3];
    logic [2:0] all_ones_q, all_ones_d;
    logic drive_en_q, drive_en_d;
    logic [2:0] pin_e3;
    logic [2:0] sel_e3, sel_sonet;

    assign pin_e3 = {ch2_e3_rate_sel, ch1_e3_rate_sel, ch0_e3_rate_sel};

    always_comb begin
        if (config_source_sel) begin
            // Host mode: rate and all-ones pins are don't-care, register copies rule
            sel_e3 = host_e3_rate_sel;
            sel_sonet = host_sonet_rate_sel;
            all_ones_d = host_all_ones_sel;
        end else begin
            sel_e3 = pin_e3;
            sel_sonet = sonet_vs_t3_rate_sel;
            all_ones_d = all_ones_tx_sel;
        end
        for (int i = 0; i < 3; i++) begin
            if (sel_e3[i]) begin
                rate_d[i] = liu_pkg::LIU_RATE_E3;
            end else if (sel_sonet[i]) begin
                rate_d[i] = liu_pkg::LIU_RATE_STS1;
            end else begin
                rate_d[i] = liu_pkg::LIU_RATE_DS3;
            end
        end
        drive_en_d = in_circuit_test_n;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 3; i++) begin
                rate_q[i] <= liu_pkg::LIU_RATE_DS3;
            end
            all_ones_q <= 3'h0;
            drive_en_q <= liu_pkg::DRIVE_EN_RESET;
        end else begin
            for (int i = 0; i < 3; i++) begin
                rate_q[i] <= rate_d[i];
            end
            all_ones_q <= all_ones_d;
            drive_en_q <= drive_en_d;
        end
    end

    assign outputs_drive_en = drive_en_q;

    // Per-channel datapath and alarms
    genvar ch;
    generate
        for (ch = 0; ch < liu_pkg::CHANNELS; ch++) begin : g_chan
            logic is_e3;
            logic rx_mark;
            logic [11:0] ref_cnt_q, ref_cnt_d;
            logic [11:0] rec_cnt_q, rec_cnt_d;
            logic lol_q, lol_d;
            logic last_pos_q, last_pos_d;
            logic viol_q, viol_d;
            logic data_q, data_d;
            logic e3_q, e3_d;
            logic sts1_q, sts1_d;

            assign is_e3 = (rate_q[ch] == liu_pkg::LIU_RATE_E3);
            assign rx_mark = rx_line_pos[ch] ^ rx_line_neg[ch];

            liu_tx_chan u_tx (
                .clk(clk),
                .rstn(rstn),
                .tx_tick(tx_tick[ch]),
                .all_ones_en(all_ones_q[ch]),
                .data_pos(tx_data_pos[ch]),
                .data_neg(tx_data_neg[ch]),
                .mon_tip(monitor_tip_in[ch]),
                .mon_ring(monitor_ring_in[ch]),
                .line_pos(line_out_positive[ch]),
                .line_neg(line_out_negative[ch]),
                .drv_alarm(driver_monitor_alarm[ch])
            );

            liu_rx_los u_los (
                .clk(clk),
                .rstn(rstn),
                .rx_tick(rx_tick[ch]),
                .mark(rx_mark),
                .is_e3(is_e3),
                .thr_sel(signal_loss_threshold_sel[ch]),
                .los(rx_signal_loss_alarm[ch])
            );

            // Lock check: recovered edges per window of reference edges
            always_comb begin
                ref_cnt_d = ref_cnt_q;
                rec_cnt_d = rec_cnt_q;
                lol_d = lol_q;
                if (rx_tick[ch] && rec_cnt_q != liu_pkg::LOL_CNT_MAX) begin
                    rec_cnt_d = rec_cnt_q + 12'h001;
                end
                if (ref_tick[ch]) begin
                    if (ref_cnt_q == liu_pkg::LOL_WINDOW - 12'h001) begin
                        // Window closes; compare and restart
                        lol_d = (rec_cnt_d > liu_pkg::LOL_WINDOW + liu_pkg::LOL_SLACK) ||
                            (rec_cnt_d < liu_pkg::LOL_WINDOW - liu_pkg::LOL_SLACK);
                        ref_cnt_d = 12'h000;
                        rec_cnt_d = 12'h000;
                    end else begin
                        ref_cnt_d = ref_cnt_q + 12'h001;
                    end
                end
            end

            // Violation: two marks in a row with the same polarity
            always_comb begin
                last_pos_d = last_pos_q;
                viol_d = viol_q;
                data_d = data_q;
                if (rx_tick[ch]) begin
                    data_d = rx_mark;
                    viol_d = rx_mark && (rx_line_pos[ch] == last_pos_q);
                    if (rx_mark) begin
                        last_pos_d = rx_line_pos[ch];
                    end
                end
            end

            // Flags follow the next rate so they answer one clock after the pins
            always_comb begin
                e3_d = (rate_d[ch] == liu_pkg::LIU_RATE_E3);
                sts1_d = (rate_d[ch] == liu_pkg::LIU_RATE_STS1);
            end

            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    ref_cnt_q <= 12'h000;
                    rec_cnt_q <= 12'h000;
                    lol_q <= liu_pkg::ALARM_RESET;
                    last_pos_q <= 1'b0;
                    viol_q <= 1'b0;
                    data_q <= 1'b0;
                    e3_q <= 1'b0;
                    sts1_q <= 1'b0;
                end else begin
                    ref_cnt_q <= ref_cnt_d;
                    rec_cnt_q <= rec_cnt_d;
                    lol_q <= lol_d;
                    last_pos_q <= last_pos_d;
                    viol_q <= viol_d;
                    data_q <= data_d;
                    e3_q <= e3_d;
                    sts1_q <= sts1_d;
                end
            end

            assign rx_lock_loss_alarm[ch] = lol_q;
            assign code_violation_pulse[ch] = viol_q;
            assign recovered_data_out[ch] = data_q;
            assign e3_mode_active[ch] = e3_q;
            assign sts1_mode_active[ch] = sts1_q;
        end
    endgenerate

endmodule

// File: design/liu_pkg.sv
package liu_pkg;

    typedef enum logic [1:0] {
        LIU_RATE_DS3,
        LIU_RATE_STS1,
        LIU_RATE_E3
    } liu_rate_t;

    localparam int unsigned CHANNELS = 3;

    // Driver monitor: silence of 128 transmit periods, inside the 128 +/- 32 band
    localparam logic [7:0] MON_SILENT_TICKS = 8'h80;

    // Loss of signal: run of zero periods before declaring
    localparam logic [7:0] LOS_E3_ZEROS = 8'h20;
    localparam logic [7:0] LOS_T3_ZEROS_LOW = 8'h64;
    localparam logic [7:0] LOS_T3_ZEROS_HIGH = 8'hAF;
    localparam logic [7:0] LOS_CNT_MAX = 8'hFF;

    // Loss of lock: reference periods per window and 0.5 percent slack
    localparam logic [11:0] LOL_WINDOW = 12'h7D0;
    localparam logic [11:0] LOL_SLACK = 12'h00A;
    localparam logic [11:0] LOL_CNT_MAX = 12'hFFF;

    // Reset values
    localparam logic DRIVE_EN_RESET = 1'b0;
    localparam logic ALARM_RESET = 1'b0;

endpackage

// File: design/liu_rx_los.sv
`timescale 1ns/100ps
module liu_rx_los (
    input wire logic clk,
    input wire logic rstn,
    input wire logic rx_tick,
    input wire logic mark,
    input wire logic is_e3,
    input wire logic thr_sel,
    output logic los
);

    logic [7:0] zeros_q, zeros_d;
    logic los_q, los_d;
    logic [7:0] limit;

    // Threshold pin only matters outside E3
    assign limit = is_e3 ? liu_pkg::LOS_E3_ZEROS :
        (thr_sel ? liu_pkg::LOS_T3_ZEROS_HIGH : liu_pkg::LOS_T3_ZEROS_LOW);

    always_comb begin
        zeros_d = zeros_q;
        los_d = los_q;
        if (rx_tick) begin
            if (mark) begin
                zeros_d = 8'h00;
                los_d = 1'b0;
            end else begin
                if (zeros_q != liu_pkg::LOS_CNT_MAX) begin
                    zeros_d = zeros_q + 8'h01;
                end
                if (zeros_q + 8'h01 >= limit) begin
                    los_d = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            zeros_q <= 8'h00;
            los_q <= liu_pkg::ALARM_RESET;
        end else begin
            zeros_q <= zeros_d;
            los_q <= los_d;
        end
    end

    assign los = los_q;

endmodule

// File: design/liu_tx_chan.sv
`timescale 1ns/100ps
module liu_tx_chan (
    input wire logic clk,
    input wire logic rstn,
    input wire logic tx_tick,
    input wire logic all_ones_en,
    input wire logic data_pos,
    input wire logic data_neg,
    input wire logic mon_tip,
    input wire logic mon_ring,
    output logic line_pos,
    output logic line_neg,
    output logic drv_alarm
);

    logic [7:0] silent_q, silent_d;
    logic alarm_q, alarm_d;
    logic pol_q, pol_d;
    logic pos_q, pos_d;
    logic neg_q, neg_d;
    logic mon_mark;

    // Idle monitor inputs sit both high; a mark drives them apart
    assign mon_mark = mon_tip ^ mon_ring;

    always_comb begin
        silent_d = silent_q;
        alarm_d = alarm_q;
        pol_d = pol_q;
        pos_d = pos_q;
        neg_d = neg_q;
        if (mon_mark) begin
            silent_d = 8'h00;
            alarm_d = 1'b0;
        end else if (tx_tick) begin
            if (silent_q != liu_pkg::MON_SILENT_TICKS) begin
                silent_d = silent_q + 8'h01;
            end
            if (silent_q == liu_pkg::MON_SILENT_TICKS - 8'h01) begin
                alarm_d = 1'b1;
            end
        end
        if (tx_tick) begin
            if (all_ones_en) begin
                pos_d = ~pol_q;
                neg_d = pol_q;
                pol_d = ~pol_q;
            end else begin
                pos_d = data_pos;
                neg_d = data_neg;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            silent_q <= 8'h00;
            alarm_q <= liu_pkg::ALARM_RESET;
            pol_q <= 1'b0;
            pos_q <= 1'b0;
            neg_q <= 1'b0;
        end else begin
            silent_q <= silent_d;
            alarm_q <= alarm_d;
            pol_q <= pol_d;
            pos_q <= pos_d;
            neg_q <= neg_d;
        end
    end

    assign line_pos = pos_q;
    assign line_neg = neg_q;
    assign drv_alarm = alarm_q;

endmodule

// File: testbench/liu_line_model.sv
`timescale 1ns/100ps
module liu_line_model (
    input wire logic [2:0] line_out_positive,
    input wire logic [2:0] line_out_negative,
    input wire logic outputs_drive_en,
    output logic [2:0] monitor_tip_in,
    output logic [2:0] monitor_ring_in
);
    // Floated driver leaves monitor pins at their pull-ups, no mark
    assign monitor_tip_in = outputs_drive_en ? ~line_out_negative : 3'h7;
    assign monitor_ring_in = outputs_drive_en ? ~line_out_positive : 3'h7;
endmodule

// File: testbench/liu_mode_alarm_bench.sv
`timescale 1ns/100ps
module liu_mode_alarm_bench;
    logic clk = 1'b0, rstn = 1'b0, config_source_sel = 1'b0, in_circuit_test_n = 1'b1;
    logic ch0_e3_rate_sel = 1'b0, ch1_e3_rate_sel = 1'b0, ch2_e3_rate_sel = 1'b0;
    logic [2:0] sonet_vs_t3_rate_sel = 3'h0, all_ones_tx_sel = 3'h0, host_all_ones_sel = 3'h0;
    logic [2:0] signal_loss_threshold_sel = 3'h0, host_e3_rate_sel = 3'h0;
    logic [2:0] host_sonet_rate_sel = 3'h0, tx_data_pos = 3'h0, tx_data_neg = 3'h0;
    logic [2:0] rx_line_pos = 3'h0, rx_line_neg = 3'h0, monitor_tip_in, monitor_ring_in;
    logic [2:0] transmit_clock, recovered_rx_clock, reference_clock_in, line_out_positive;
    logic [2:0] line_out_negative, driver_monitor_alarm, rx_signal_loss_alarm;
    logic [2:0] rx_lock_loss_alarm, code_violation_pulse, e3_mode_active, sts1_mode_active;
    logic outputs_drive_en;
    logic [2:0] recovered_data_out;
    int fail_count = 0, tests_run = 0, cyc = 0, rc = 0, rx_per = 4, viol_hi = 0, viol_seen = 0;
    initial forever #12.5 clk = ~clk;
    always @(negedge clk) begin
        cyc <= cyc + 1;
        rc <= (rc + 1) % rx_per;
    end
    // Reference shares the transmit rate; all channels run alike
    assign transmit_clock = {3{cyc[1]}};
    assign reference_clock_in = {3{cyc[1]}};
    assign recovered_rx_clock = {3{rc >= rx_per / 2}};
    always @(negedge clk) if (code_violation_pulse[0] === 1'b1) viol_hi++;
    // Terminal side samples the pulse on the recovered clock
    always @(posedge recovered_rx_clock[0]) begin
        if (code_violation_pulse[0] === 1'b1) viol_seen++;
    end
    liu_mode_alarm uut (.clk, .rstn, .config_source_sel, .in_circuit_test_n, .ch0_e3_rate_sel,
        .ch1_e3_rate_sel, .ch2_e3_rate_sel, .sonet_vs_t3_rate_sel, .all_ones_tx_sel,
        .signal_loss_threshold_sel, .host_e3_rate_sel, .host_sonet_rate_sel,
        .host_all_ones_sel, .transmit_clock, .tx_data_pos, .tx_data_neg, .monitor_tip_in,
        .monitor_ring_in, .recovered_rx_clock, .reference_clock_in, .rx_line_pos,
        .rx_line_neg, .line_out_positive, .line_out_negative, .driver_monitor_alarm,
        .rx_signal_loss_alarm, .rx_lock_loss_alarm, .code_violation_pulse,
        .recovered_data_out, .e3_mode_active, .sts1_mode_active, .outputs_drive_en);
    liu_line_model line (.line_out_positive, .line_out_negative, .outputs_drive_en,
        .monitor_tip_in, .monitor_ring_in);
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic clks(input int n);
        repeat (n) @(negedge clk);
    endtask
    // One symbol per receive period of four clocks
    task automatic sym(input logic p, input logic n, input int k);
        rx_line_pos = {3{p}};
        rx_line_neg = {3{n}};
        clks(4 * k);
    endtask
    task automatic rst;
        rstn = 1'b0;
        clks(16);
        rstn = 1'b1;
        clks(2);
    endtask
    task automatic t_mode;
        for (int i = 0; i < 8; i++) begin
            logic [2:0] v;
            v = 3'(i);
            config_source_sel = 1'b0;
            {ch2_e3_rate_sel, ch1_e3_rate_sel, ch0_e3_rate_sel} = {v[2], v[2], v[0]};
            sonet_vs_t3_rate_sel = {3{v[1]}};
            host_e3_rate_sel = ~v;
            host_sonet_rate_sel = v;
            clks(2);
            chk("e3", {v[2], v[2], v[0]}, e3_mode_active);
            chk("sts1", {3{v[1]}} & ~{v[2], v[2], v[0]}, sts1_mode_active);
            config_source_sel = 1'b1;
            clks(2);
            chk("host e3", {5'h00, ~v}, e3_mode_active);
            chk("host sts1", v, sts1_mode_active);
        end
        config_source_sel = 1'b0;
        {ch2_e3_rate_sel, ch1_e3_rate_sel, ch0_e3_rate_sel} = 3'h0;
    endtask
    task automatic t_test_float;
        in_circuit_test_n = 1'b0;
        clks(2);
        chk("drive en", 8'h00, outputs_drive_en);
        in_circuit_test_n = 1'b1;
        clks(2);
        chk("drive en", 8'h01, outputs_drive_en);
    endtask
    task automatic t_aos;
        logic [2:0] pv;
        all_ones_tx_sel = 3'h7;
        config_source_sel = 1'b1;
        clks(12);
        chk("host idle", 8'h00, line_out_positive | line_out_negative);
        config_source_sel = 1'b0;
        clks(8);
        pv = line_out_positive;
        repeat (6) begin
            clks(4);
            chk("mark", 8'h07, line_out_positive ^ line_out_negative);
            chk("alternate", {5'h00, ~pv}, line_out_positive);
            pv = line_out_positive;
        end
        chk("drive monitor quiet", 8'h00, driver_monitor_alarm);
        all_ones_tx_sel = 3'h0;
        host_all_ones_sel = 3'h7;
        config_source_sel = 1'b1;
        clks(12);
        chk("host aos", 8'h07, line_out_positive ^ line_out_negative);
        host_all_ones_sel = 3'h0;
        config_source_sel = 1'b0;
        clks(8);
    endtask
    task automatic t_drv_mon;
        tx_data_pos = 3'h7;
        clks(4);
        tx_data_pos = 3'h0;
        clks(4 * 126);
        chk("drive monitor early", 8'h00, driver_monitor_alarm);
        clks(16);
        chk("drive monitor set", 8'h07, driver_monitor_alarm);
        tx_data_neg = 3'h7;
        clks(4);
        chk("line neg", 8'h07, line_out_negative);
        tx_data_neg = 3'h0;
        clks(4);
        chk("drive monitor clear", 8'h00, driver_monitor_alarm);
    endtask
    // Threshold changes only across a reset, as a board would
    task automatic t_los(input logic e3, input logic thr, input int n);
        signal_loss_threshold_sel = {3{thr}};
        {ch2_e3_rate_sel, ch1_e3_rate_sel, ch0_e3_rate_sel} = {3{e3}};
        rst;
        sym(1'b1, 1'b0, 1);
        sym(1'b0, 1'b0, n - 1);
        chk("los early", 8'h00, rx_signal_loss_alarm);
        sym(1'b0, 1'b0, 3);
        chk("los set", 8'h07, rx_signal_loss_alarm);
        sym(1'b0, 1'b1, 1);
        sym(1'b0, 1'b0, 1);
        chk("los clear", 8'h00, rx_signal_loss_alarm);
    endtask
    task automatic t_viol;
        rst;
        viol_hi = 0;
        viol_seen = 0;
        sym(1'b1, 1'b0, 1);
        chk("rx data", 8'h07, recovered_data_out);
        sym(1'b0, 1'b1, 1);
        chk("no violation", 8'h00, code_violation_pulse);
        sym(1'b1, 1'b0, 2);
        chk("violation", 8'h07, code_violation_pulse);
        sym(1'b0, 1'b0, 3);
        chk("rx data idle", 8'h00, recovered_data_out);
        chk("violation width", 8'h04, 8'(viol_hi));
        chk("violation seen", 8'h01, 8'(viol_seen));
    endtask
    task automatic t_lol;
        rst;
        clks(16020);
        chk("lol locked", 8'h00, rx_lock_loss_alarm);
        rx_per = 5;
        clks(24000);
        chk("lol set", 8'h07, rx_lock_loss_alarm);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #1500000;
        fail_count++;
        report_and_stop;
    end
    initial begin
        clks(16);
        rstn = 1'b1;
        clks(2);
        t_mode;
        t_test_float;
        t_aos;
        t_drv_mon;
        t_los(1'b1, 1'b0, 32);
        t_los(1'b1, 1'b1, 32);
        t_los(1'b0, 1'b0, 100);
        t_los(1'b0, 1'b1, 175);
        t_viol;
        t_lol;
        report_and_stop;
    end
endmodule

// File: testbench/liu_mode_alarm_monitor.sv
`timescale 1ns/100ps
module liu_mode_alarm_monitor (
    input wire logic clk,
    input wire logic rstn,
    input wire logic config_source_sel,
    input wire logic in_circuit_test_n,
    input wire logic ch0_e3_rate_sel,
    input wire logic ch1_e3_rate_sel,
    input wire logic [2:0] sonet_vs_t3_rate_sel,
    input wire logic [2:0] host_e3_rate_sel,
    input wire logic [2:0] monitor_tip_in,
    input wire logic [2:0] monitor_ring_in,
    input wire logic [2:0] recovered_rx_clock,
    input wire logic [2:0] reference_clock_in,
    input wire logic [2:0] driver_monitor_alarm,
    input wire logic [2:0] rx_lock_loss_alarm,
    input wire logic [2:0] code_violation_pulse,
    input wire logic [2:0] e3_mode_active,
    input wire logic [2:0] sts1_mode_active,
    input wire logic outputs_drive_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_e3_ch0;
        !config_source_sel && ch0_e3_rate_sel |=> e3_mode_active[0] && !sts1_mode_active[0];
    endproperty
    a_e3_ch0: assert property (p_e3_ch0) else $error("ch0 not E3");
    property p_e3_ch1;
        !config_source_sel && ch1_e3_rate_sel |=> e3_mode_active[1];
    endproperty
    a_e3_ch1: assert property (p_e3_ch1) else $error("ch1 not E3");
    property p_sts;
        !config_source_sel && !ch0_e3_rate_sel && sonet_vs_t3_rate_sel[0] |=> sts1_mode_active[0];
    endproperty
    a_sts: assert property (p_sts) else $error("ch0 not STS-1");
    property p_host;
        config_source_sel |=> e3_mode_active == $past(host_e3_rate_sel);
    endproperty
    a_host: assert property (p_host) else $error("host rate not taken");
    property p_test_float;
        $fell(in_circuit_test_n) |=> !outputs_drive_en;
    endproperty
    a_test_float: assert property (p_test_float) else $error("outputs still driven");
    property p_drv_mon;
        monitor_tip_in[0] != monitor_ring_in[0] |=> !driver_monitor_alarm[0];
    endproperty
    a_drv_mon: assert property (p_drv_mon) else $error("monitor alarm kept");
    property p_viol;
        !$stable(code_violation_pulse[0]) |-> recovered_rx_clock[0] || $past(recovered_rx_clock[0]);
    endproperty
    a_viol: assert property (p_viol) else $error("violation pulse off tick");
    property p_lol;
        !$stable(rx_lock_loss_alarm[0]) |-> reference_clock_in[0] || $past(reference_clock_in[0]);
    endproperty
    a_lol: assert property (p_lol) else $error("lock alarm off tick");
    c_drv_mon: cover property (driver_monitor_alarm[0]);
    c_viol: cover property (code_violation_pulse[0]);
    c_lol: cover property (rx_lock_loss_alarm[0]);
endmodule
bind liu_mode_alarm liu_mode_alarm_monitor mon (.clk, .rstn, .config_source_sel,
    .in_circuit_test_n, .ch0_e3_rate_sel, .ch1_e3_rate_sel, .sonet_vs_t3_rate_sel,
    .host_e3_rate_sel, .monitor_tip_in, .monitor_ring_in, .recovered_rx_clock,
    .reference_clock_in, .driver_monitor_alarm, .rx_lock_loss_alarm, .code_violation_pulse,
    .e3_mode_active, .sts1_mode_active, .outputs_drive_en);
